// ==== design/ec_port_cfg.svh ====
`ifndef EC_PORT_CFG_SVH
`define EC_PORT_CFG_SVH
// bus widths
`define EC_ADDR_W 11
`define EC_DATA_W 8
// reset values
`define EC_DATA_RST 8'h00
`define EC_ADDR_RST 11'h000
// width and depth of the pending interrupt queue count
`define EC_IRQ_CNT_W 6
`define EC_IRQ_CNT_MAX 6'h20
`define EC_IRQ_CNT_RST 6'h00
// address of the interrupt queue read port
`define EC_IRQ_FIFO_ADDR 11'h000
`endif

// ==== design/ec_port_pkg.sv ====
package ec_port_pkg;
`include "ec_port_cfg.svh"
    typedef logic [`EC_ADDR_W-1:0] addr_t;
    typedef logic [`EC_DATA_W-1:0] data_t;
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_ACC = 2'b01,
        DEV_DONE = 2'b11
    } dev_state_t;
    typedef enum logic [1:0] {
        HST_IDLE = 2'b00,
        HST_WAIT = 2'b01,
        HST_END = 2'b11
    } hst_state_t;
endpackage

// ==== design/ec_port_if.sv ====
`timescale 1ns/10ps
interface ec_port_if;
    import ec_port_pkg::*;
    logic port_select_n;
    logic write_strobe_n;
    logic read_not_write;
    addr_t addr;
    data_t host_data;
    logic host_data_oe_n;
    data_t dev_data;
    logic dev_data_oe_n;
    logic transfer_ack_n_out;
    logic transfer_ack_n_oe_n;
    logic interrupt_request_n_out;
    logic interrupt_request_n_oe_n;
    // resolved shared wires; pull-ups on the open-drain lines
    wire data_t data_bus = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : 8'hFF);
    wire transfer_ack_n = transfer_ack_n_oe_n ? 1'b1 : transfer_ack_n_out;
    wire interrupt_request_n = interrupt_request_n_oe_n ? 1'b1 : interrupt_request_n_out;
    modport dev (
        input port_select_n, write_strobe_n, read_not_write, addr, data_bus,
        output dev_data, dev_data_oe_n, transfer_ack_n_out, transfer_ack_n_oe_n,
        output interrupt_request_n_out, interrupt_request_n_oe_n
    );
    modport host (
        output port_select_n, write_strobe_n, read_not_write, addr, host_data, host_data_oe_n,
        input data_bus, transfer_ack_n, interrupt_request_n
    );
endinterface // ec_port_if

// ==== design/ec_port_dev.sv ====
// What this block does
// - irq line low on any channel interrupt
// - irq released once fifo read empty
// - host writes with strobe and select low
// - respond only while select held low
// - drive data on reads, sample on writes
// - ack low marks transfer finished
// - eight-bit data bus, byte per access
// - eleven-bit register address A10..A0
`timescale 1ns/10ps
`include "ec_port_cfg.svh"

module ec_port_dev
    import ec_port_pkg::*;
(
    input wire logic clk_i, // 25 MHz clock
    input wire logic rst_n_i, // async reset, active low
    ec_port_if.dev bus, // host-facing pins
    input wire logic chan_irq_i, // one-cycle channel interrupt event
    input wire data_t irq_code_i, // code queued with the event
    output addr_t reg_addr_o, // register address of access
    output data_t reg_wdata_o, // write data
    output logic reg_wr_o, // write pulse
    output logic reg_rd_o, // read pulse
    input wire data_t reg_rdata_i // read data for non-queue addresses
);
    // all port state except the queue storage, registered as one word
    typedef struct packed {
        // two-flop synchronisers for the host pins
        logic [1:0] cs_sync; // select, [1] is the settled copy
        logic [1:0] ds_sync; // write strobe
        logic [1:0] rw_sync; // direction, 1 read
        addr_t [1:0] a_sync; // address lines
        data_t [1:0] d_sync; // data lines as seen on the bus

        // access control and the pin-side answer
        dev_state_t st; // access state
        data_t rdata; // byte driven back on reads
        logic drive; // device owns the data lines
        logic ack; // pull the acknowledge line low

        // register-side view of the access
        addr_t addr; // address of the last access
        data_t wdata; // byte of the last write
        logic wr; // one-cycle write pulse
        logic rd; // one-cycle read pulse

        // interrupt queue bookkeeping
        logic [`EC_IRQ_CNT_W-1:0] pend; // entries waiting to be read
        logic [4:0] wp; // next slot to fill
        logic [4:0] rp; // next slot to hand out
    } dev_s_t;

    dev_s_t cur_ff, nxt_s;
    // one entry per pending channel interrupt code
    data_t fifo_mem [0:31];
    logic push; // queue a channel event this cycle
    logic pop; // hand out the head entry this cycle
    logic cs_act; // settled select, active
    logic ds_act; // settled write strobe, active
    logic is_rd; // settled direction, 1 read
    logic q_empty; // nothing waiting
    logic q_full; // no free slot
    logic at_queue; // access aims at the queue address
    data_t q_head; // byte at the read side of the queue

    // pins come from the host's domain, so two flops before use
    assign cs_act = !cur_ff.cs_sync[1];
    assign ds_act = !cur_ff.ds_sync[1];
    assign is_rd = cur_ff.rw_sync[1];

    // queue level flags; full means every slot holds an unread code
    assign q_empty = (cur_ff.pend == `EC_IRQ_CNT_RST);
    assign q_full = (cur_ff.pend == `EC_IRQ_CNT_MAX);
    // the queue sits at one fixed address
    assign at_queue = (cur_ff.a_sync[1] == `EC_IRQ_FIFO_ADDR);
    // an empty queue reads as the reset byte, never a stale or unwritten slot
    assign q_head = q_empty ? `EC_DATA_RST : fifo_mem[cur_ff.rp];

    // every channel event is queued unless the queue is full
    // a full queue drops the new event; software must drain it in time
    assign push = chan_irq_i && !q_full;
    // a queue read pops one entry; reading it empty pops nothing
    assign pop = (cur_ff.st == DEV_ACC) && cs_act && is_rd && at_queue && !q_empty;

    // access walk, counted from the edge that drops select on the pins:
    //  +2 the settled select is seen, +3 the access state is entered,
    //  +4 ack and, on reads, the byte appear, and the register strobe fires;
    //  ack then stands until the settled select goes high again
    always_comb begin
        nxt_s = cur_ff;
        // shift the pins one stage on; the settled copies are read below
        nxt_s.cs_sync = {cur_ff.cs_sync[0], bus.port_select_n};
        nxt_s.ds_sync = {cur_ff.ds_sync[0], bus.write_strobe_n};
        nxt_s.rw_sync = {cur_ff.rw_sync[0], bus.read_not_write};
        nxt_s.a_sync = {cur_ff.a_sync[0], bus.addr};
        nxt_s.d_sync = {cur_ff.d_sync[0], bus.data_bus};

        // register strobes last one cycle only
        nxt_s.wr = 1'b0;
        nxt_s.rd = 1'b0;

        unique case (cur_ff.st)
            DEV_IDLE: begin
                // select gates everything
                // a write select without its strobe is ignored here
                // direction comes from the same settled stage as select
                if (cs_act && (is_rd || ds_act)) begin
                    nxt_s.st = DEV_ACC;
                end
            end
            DEV_ACC: begin
                // address and data copies took the same delay as select
                nxt_s.addr = cur_ff.a_sync[1];
                if (!cs_act) begin
                    // host gave up before the answer
                    nxt_s.st = DEV_IDLE;
                end else if (is_rd) begin
                    // read: drive bus
                    // other addresses come from the register file
                    nxt_s.rdata = at_queue ? q_head : reg_rdata_i;
                    nxt_s.drive = 1'b1;
                    nxt_s.rd = 1'b1;
                    nxt_s.ack = 1'b1;
                    nxt_s.st = DEV_DONE;
                end else if (ds_act) begin
                    nxt_s.wdata = cur_ff.d_sync[1];
                    nxt_s.wr = 1'b1;
                    nxt_s.ack = 1'b1;
                    nxt_s.st = DEV_DONE;
                end else begin
                    // strobe withdrawn early: drop the write, stay off the bus
                    nxt_s.st = DEV_IDLE;
                end
            end
            DEV_DONE: begin
                // hold ack until deselect, then free bus
                // the host sees ack only after its own sync, so it must stand till then
                if (!cs_act) begin
                    nxt_s.ack = 1'b0;
                    nxt_s.drive = 1'b0;
                    nxt_s.st = DEV_IDLE;
                end
            end
            // the unused code falls back to idle
            default: begin
                nxt_s.st = DEV_IDLE;
            end
        endcase

        if (push) begin
            nxt_s.wp = cur_ff.wp + 5'h01;
        end
        // each queue read frees one slot
        if (pop) begin
            nxt_s.rp = cur_ff.rp + 5'h01;
        end
        // simultaneous push and pop keep the count; at full the push is still dropped even with a pop in the same cycle
        nxt_s.pend = cur_ff.pend + {5'h00, push} - {5'h00, pop};
    end

    // state register
    // select and strobe copies reset to their idle high level, so no false access follows reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_ff <= '0;
            cur_ff.cs_sync <= 2'b11;
            cur_ff.ds_sync <= 2'b11;
            cur_ff.st <= DEV_IDLE;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    // queue storage holds no control state, so it needs no reset
    // writes land at the fill pointer; reads use the hand-out pointer
    always_ff @(posedge clk_i) begin
        if (push) begin
            fifo_mem[cur_ff.wp] <= irq_code_i;
        end
    end

    // open-drain ack, enable low pulls low
    assign bus.transfer_ack_n_out = 1'b0;
    assign bus.transfer_ack_n_oe_n = !cur_ff.ack;
    // pulled low as soon as an event is queued
    // line stays low while queue not empty
    assign bus.interrupt_request_n_out = 1'b0;
    assign bus.interrupt_request_n_oe_n = q_empty;

    // read byte from flops, so it cannot glitch while ack stands
    assign bus.dev_data = cur_ff.rdata;
    assign bus.dev_data_oe_n = !cur_ff.drive;

    // register side: strobes and their qualifiers from the same flops
    assign reg_addr_o = cur_ff.addr;
    assign reg_wdata_o = cur_ff.wdata;
    assign reg_wr_o = cur_ff.wr;
    assign reg_rd_o = cur_ff.rd;
endmodule // ec_port_dev

// ==== design/ec_port_host.sv ====
`timescale 1ns/10ps
module ec_port_host
    import ec_port_pkg::*;
(
    input wire logic clk_i, // 25 MHz clock
    input wire logic rst_n_i, // async reset, active low
    ec_port_if.host bus, // device-facing pins
    input wire logic req_i, // start an access, taken when ready_o
    input wire logic req_rd_i, // 1 read, 0 write
    input wire addr_t req_addr_i, // register address
    input wire data_t req_wdata_i, // write data
    output logic ready_o, // idle, can take a request
    output logic done_o, // one-cycle pulse at access end
    output data_t rdata_o, // read data, valid with done_o
    output logic irq_o // synchronised interrupt level
);
    typedef struct packed {
        hst_state_t st;
        logic cs;
        logic ds;
        logic rd;
        addr_t addr;
        data_t wdata;
        logic drive;
        data_t rdata;
        logic done;
        logic [1:0] ack_sync;
        logic [1:0] irq_sync;
        data_t [1:0] d_sync;
    } hst_s_t;

    hst_s_t cur_ff, nxt_s;
    logic ack_seen;

    assign ack_seen = !cur_ff.ack_sync[1];

    // next state
    always_comb begin
        nxt_s = cur_ff;
        nxt_s.ack_sync = {cur_ff.ack_sync[0], bus.transfer_ack_n};
        nxt_s.irq_sync = {cur_ff.irq_sync[0], bus.interrupt_request_n};
        nxt_s.d_sync = {cur_ff.d_sync[0], bus.data_bus};
        nxt_s.done = 1'b0;
        unique case (cur_ff.st)
            HST_IDLE: begin
                // wait for ack from the previous access to clear
                if (req_i && !ack_seen) begin
                    nxt_s.cs = 1'b1;
                    nxt_s.rd = req_rd_i;
                    nxt_s.addr = req_addr_i;
                    nxt_s.wdata = req_wdata_i;
                    nxt_s.ds = !req_rd_i;
                    // host drives the byte only on writes
                    nxt_s.drive = !req_rd_i;
                    nxt_s.st = HST_WAIT;
                end
            end
            HST_WAIT: begin
                if (ack_seen) begin
                    nxt_s.rdata = cur_ff.rd ? cur_ff.d_sync[1] : cur_ff.rdata;
                    nxt_s.cs = 1'b0;
                    nxt_s.ds = 1'b0;
                    nxt_s.drive = 1'b0;
                    nxt_s.st = HST_END;
                end
            end
            HST_END: begin
                if (!ack_seen) begin
                    nxt_s.done = 1'b1;
                    nxt_s.st = HST_IDLE;
                end
            end
            default: begin
                nxt_s.st = HST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_ff <= '0;
            cur_ff.ack_sync <= 2'b11;
            cur_ff.irq_sync <= 2'b11;
            cur_ff.st <= HST_IDLE;
        end else begin
            cur_ff <= nxt_s;
        end
    end

    assign bus.port_select_n = !cur_ff.cs;
    assign bus.write_strobe_n = !cur_ff.ds;
    assign bus.read_not_write = cur_ff.rd;
    assign bus.addr = cur_ff.addr;
    assign bus.host_data = cur_ff.wdata;
    assign bus.host_data_oe_n = !cur_ff.drive;
    assign ready_o = (cur_ff.st == HST_IDLE) && !ack_seen;
    assign done_o = cur_ff.done;
    assign rdata_o = cur_ff.rdata;
    assign irq_o = !cur_ff.irq_sync[1];
endmodule // ec_port_host

// ==== tb/ec_port_monitor.sv ====
`timescale 1ns/10ps
module ec_port_monitor
    import ec_port_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, active low
    input wire logic port_select_n, // select from host
    input wire logic write_strobe_n, // strobe from host
    input wire logic read_not_write, // 1 read
    input wire addr_t addr, // register address
    input wire data_t data_bus, // resolved data lines
    input wire logic dev_data_oe_n, // device drive, low on
    input wire logic transfer_ack_n, // resolved ack
    input wire logic interrupt_request_n // resolved interrupt line
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // access start and its answer; ack crosses a sync, hence the window
    sequence s_start;
        $fell(port_select_n) && (read_not_write || !write_strobe_n);
    endsequence
    sequence s_ack;
        ##[1:8] !transfer_ack_n;
    endsequence
    property p_ack_bound;
        s_start |-> s_ack;
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("no ack after select");
    property p_ack_holds;
        !transfer_ack_n && !port_select_n |=> !transfer_ack_n;
    endproperty
    a_ack_holds: assert property (p_ack_holds) else $error("ack dropped early");
    property p_ack_sel;
        $fell(transfer_ack_n) |-> !port_select_n;
    endproperty
    a_ack_sel: assert property (p_ack_sel) else $error("ack without select");
    property p_drive_rd;
        $fell(dev_data_oe_n) |-> read_not_write && !port_select_n;
    endproperty
    a_drive_rd: assert property (p_drive_rd) else $error("device drove off a read");
    property p_quiet_wr;
        !port_select_n && !read_not_write |-> dev_data_oe_n;
    endproperty
    a_quiet_wr: assert property (p_quiet_wr) else $error("device drove on a write");
    property p_byte_held;
        !transfer_ack_n && read_not_write && !port_select_n |-> !dev_data_oe_n ##1 (transfer_ack_n || $stable(data_bus));
    endproperty
    a_byte_held: assert property (p_byte_held) else $error("read byte not held");
    property p_addr_held;
        !port_select_n && transfer_ack_n |=> port_select_n || $stable(addr);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved mid access");
    property p_release;
        $rose(port_select_n) |-> ##[0:8] (transfer_ack_n && dev_data_oe_n);
    endproperty
    a_release: assert property (p_release) else $error("bus not released");
    // only a read access may let the interrupt line go high
    property p_irq_release;
        $rose(interrupt_request_n) |-> !port_select_n && read_not_write;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("irq released outside a read");
endmodule // ec_port_monitor

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import ec_port_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, chan_irq_i = 1'b0, req_i = 1'b0, req_rd_i = 1'b0;
    data_t irq_code_i = 8'h00, req_wdata_i = 8'h00, reg_rdata_i = 8'h00, rdata_o, reg_wdata_o, got;
    data_t seen_wdata = 8'h00;
    addr_t req_addr_i = 11'h000, reg_addr_o, seen_addr = 11'h000;
    logic reg_wr_o, reg_rd_o, ready_o, done_o, irq_o, seen_wr = 1'b0;
    int errors = 0, tests_run = 0;
    // free running clock
    always #20 clk_i = ~clk_i;
    ec_port_if bus_if ();
    ec_port_dev ec_port_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if), .chan_irq_i(chan_irq_i),
        .irq_code_i(irq_code_i), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
        .reg_rd_o(reg_rd_o), .reg_rdata_i(reg_rdata_i));
    ec_port_host ec_port_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if), .req_i(req_i),
        .req_rd_i(req_rd_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ready_o(ready_o),
        .done_o(done_o), .rdata_o(rdata_o), .irq_o(irq_o));
    ec_port_monitor ec_port_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .port_select_n(bus_if.port_select_n),
        .write_strobe_n(bus_if.write_strobe_n), .read_not_write(bus_if.read_not_write), .addr(bus_if.addr),
        .data_bus(bus_if.data_bus), .dev_data_oe_n(bus_if.dev_data_oe_n), .transfer_ack_n(bus_if.transfer_ack_n),
        .interrupt_request_n(bus_if.interrupt_request_n));
    // keep the last register strobe, since the pulse is gone before the host finishes
    always @(posedge clk_i) begin
        if (reg_wr_o === 1'b1 || reg_rd_o === 1'b1) begin
            seen_addr <= reg_addr_o;
            seen_wdata <= reg_wdata_o;
            seen_wr <= reg_wr_o;
        end
    end
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk_val(input addr_t g, input addr_t e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        chk_val({10'h000, g}, {10'h000, e});
    endtask
    // bounded wait at the falling edge, where outputs are settled
    // on_done 1 waits for done_o, 0 for ready_o
    task automatic wait_for(input bit on_done);
        int n;
        n = 0;
        while ((on_done ? done_o : ready_o) !== 1'b1 && n < 60) begin
            @(negedge clk_i);
            n++;
        end
        if ((on_done ? done_o : ready_o) !== 1'b1) begin
            errors++;
            give_verdict();
        end
    endtask
    task automatic access(input logic rd, input addr_t a, input data_t d);
        wait_for(1'b0);
        @(posedge clk_i);
        req_i <= 1'b1;
        req_rd_i <= rd;
        req_addr_i <= a;
        req_wdata_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        @(negedge clk_i);
        wait_for(1'b1);
        got = rdata_o;
    endtask
    task automatic test_write();
        access(1'b0, 11'h7FF, 8'hA5);
        chk_val(seen_addr, 11'h7FF);
        chk_val({3'h0, seen_wdata}, 11'h0A5);
        chk_bit(seen_wr, 1'b1);
        chk_val({3'h0, bus_if.data_bus}, 11'h0FF);
        chk_bit(bus_if.transfer_ack_n, 1'b1);
        $display("test_write done");
    endtask
    task automatic test_read();
        @(posedge clk_i);
        reg_rdata_i <= 8'h3C;
        access(1'b1, 11'h555, 8'h00);
        chk_val({3'h0, got}, 11'h03C);
        chk_val(seen_addr, 11'h555);
        chk_bit(seen_wr, 1'b0);
        $display("test_read done");
    endtask
    // two queued events, then drained back to back
    task automatic test_irq();
        @(posedge clk_i);
        chan_irq_i <= 1'b1;
        irq_code_i <= 8'h81;
        @(posedge clk_i);
        irq_code_i <= 8'h42;
        @(posedge clk_i);
        chan_irq_i <= 1'b0;
        repeat (6) @(negedge clk_i);
        chk_bit(bus_if.interrupt_request_n, 1'b0);
        chk_bit(irq_o, 1'b1);
        access(1'b1, 11'h000, 8'h00);
        chk_val({3'h0, got}, 11'h081);
        chk_bit(bus_if.interrupt_request_n, 1'b0);
        access(1'b1, 11'h000, 8'h00);
        chk_val({3'h0, got}, 11'h042);
        chk_bit(bus_if.interrupt_request_n, 1'b1);
        chk_bit(irq_o, 1'b0);
        // an empty queue reads as the reset byte and leaves the line high
        access(1'b1, 11'h000, 8'h00);
        chk_val({3'h0, got}, 11'h000);
        chk_bit(bus_if.interrupt_request_n, 1'b1);
        $display("test_irq done");
    endtask
    // reset for three cycles, then the scenarios in turn
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        test_write();
        test_read();
        test_irq();
        give_verdict();
    end
endmodule // tb_top
